// ### tca_pkg.sv
/*
 * Shared constants and types for the tri-state conduit arbiter.
 * Assumes a single synchronous clock domain and an active-low asynchronous reset.
 */
package tca_pkg;
    // =========================================================================
    // Sizing defaults
    // =========================================================================
    localparam int TCA_NUM_MASTERS = 2;
    localparam int TCA_PIN_W = 16;
    localparam int TCA_PIN_W_MIN = 1;
    localparam int TCA_PIN_W_MAX = 1024;

    // =========================================================================
    // Timing counts in mclk cycles
    // =========================================================================
    localparam int TCA_SYNC_STAGES = 3;
    localparam int TCA_MIN_ACCESS = 2;
    localparam int TCA_RELEASE_LAG = 1;

    // =========================================================================
    // Reset values
    // =========================================================================
    localparam logic TCA_GRANT_RST = 1'b0;
    localparam logic TCA_OE_RST = 1'b0;
    localparam logic TCA_PIN_RST = 1'b0;

    // =========================================================================
    // Arbiter states
    // =========================================================================
    typedef enum logic {
        TCA_ARB_IDLE,
        TCA_ARB_OWNED
    } tca_arb_state_t;
endpackage

// ### tca_pin_sync.sv
/*
 * Three-stage synchroniser for the shared pin inputs, with an agreement filter.
 * Assumes the pins are asynchronous to mclk and that ce freezes all state.
 */
`timescale 1ns/10ps
module tca_pin_sync #(
    parameter int W = tca_pkg::TCA_PIN_W
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [W-1:0] pinRaw,
    output logic [W-1:0] pinSync
);
    import tca_pkg::*;

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    wire [W-1:0] agree = ~(stage2 ^ stage3);
    wire [W-1:0] next_pinSync = (agree & stage3) | (~agree & pinSync);

    // =========================================================================
    // Sampling chain
    // =========================================================================
    // A bit only moves once stages two and three agree, so a level that is
    // still settling in the first stage never reaches the masters.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= {W{TCA_PIN_RST}};
            stage2 <= {W{TCA_PIN_RST}};
            stage3 <= {W{TCA_PIN_RST}};
            pinSync <= {W{TCA_PIN_RST}};
        end else if (ce) begin
            stage1 <= pinRaw;
            stage2 <= stage1;
            stage3 <= stage2;
            pinSync <= next_pinSync;
        end
    end
endmodule

// ### tca_arbiter.sv
/*
 * Slave-side arbiter of a shared tri-state pin conduit: grants the pins to one
 * requesting master at a time and carries the owner's pin drive to the pads.
 * Assumes masters on mclk that keep their side of the request handshake,
 * and pads whose input level is asynchronous to mclk.
 */
// What this block does
// - Request with grant low asks now.
// - Request with grant high keeps next cycle.
// - Immediate re-request allows rearbitration or continuation.
// - Every access lasts at least two cycles.
// - Grant only answers a pending request.
// - Grant drops one cycle after request drops.
// - Sampled pin input is driven to masters.
// - Signals mean the same on both sides.
`timescale 1ns/10ps
module tca_arbiter #(
    parameter int NUM_MASTERS = tca_pkg::TCA_NUM_MASTERS,
    parameter int PIN_W = tca_pkg::TCA_PIN_W
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [NUM_MASTERS-1:0] request,
    output logic [NUM_MASTERS-1:0] grant,
    input wire logic [NUM_MASTERS*PIN_W-1:0] masterOut,
    input wire logic [NUM_MASTERS-1:0] masterOutEn,
    output logic [PIN_W-1:0] pinIn,
    input wire logic [PIN_W-1:0] padIn,
    output logic [PIN_W-1:0] padOut,
    output logic padOutEn
);
    import tca_pkg::*;

    localparam int OWN_W = (NUM_MASTERS > 1) ? $clog2(NUM_MASTERS) : 1;

    // =========================================================================
    // Helper functions
    // =========================================================================
    // Round robin: the search starts just after the last owner, so a master
    // that re-requests at once only wins again when nobody else is waiting.
    function automatic logic [OWN_W-1:0] rrPick(
        input logic [NUM_MASTERS-1:0] req,
        input logic [OWN_W-1:0] last
    );
        logic [OWN_W-1:0] sel;
        logic found;
        int idx;
        sel = last;
        found = 1'b0;
        idx = 0;
        for (int k = 1; k <= NUM_MASTERS; k++) begin
            idx = (int'(last) + k) % NUM_MASTERS;
            if (!found && req[idx]) begin
                sel = OWN_W'(idx);
                found = 1'b1;
            end
        end
        return sel;
    endfunction

    function automatic logic [NUM_MASTERS-1:0] oneHot(input logic [OWN_W-1:0] idx);
        logic [NUM_MASTERS-1:0] v;
        v = '0;
        v[idx] = 1'b1;
        return v;
    endfunction

    // =========================================================================
    // Arbitration decode
    // =========================================================================
    tca_arb_state_t state;
    tca_arb_state_t next_state;
    logic [OWN_W-1:0] owner;
    logic [OWN_W-1:0] next_owner;
    logic [NUM_MASTERS-1:0] next_grant;
    logic [PIN_W-1:0] next_padOut;
    logic next_padOutEn;

    wire anyReq = |request;
    wire ownerReq = request[owner];
    wire [OWN_W-1:0] winner = rrPick(request, owner);
    wire isOwned = (state == TCA_ARB_OWNED);
    wire [PIN_W-1:0] ownerOut = masterOut[int'(owner)*PIN_W +: PIN_W];

    // new award
    // A request seen while idle asks for this cycle; the grant follows on the
    // next edge, which also makes an access span at least two cycles.
    // hold or release
    // The owner keeps the pins while its request stays high; the cycle after
    // it drops request, the grant falls and the arbiter is free again.
    always_comb begin
        next_state = state;
        next_owner = owner;
        unique case (state)
            TCA_ARB_IDLE: begin
                if (anyReq) begin
                    next_state = TCA_ARB_OWNED;
                    next_owner = winner;
                end
            end
            TCA_ARB_OWNED: begin
                if (!ownerReq) begin
                    next_state = TCA_ARB_IDLE;
                end
            end
        endcase
    end

    assign next_grant = (next_state == TCA_ARB_OWNED) ? oneHot(next_owner) : '0;

    // pin drive pass
    // Only the current owner's value and enable reach the pads; with no owner
    // the pads are released so no two masters can ever contend.
    assign next_padOut = isOwned ? ownerOut : padOut;
    assign next_padOutEn = isOwned & masterOutEn[owner];

    // =========================================================================
    // State registers
    // =========================================================================
    // reset to idle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= TCA_ARB_IDLE;
            owner <= '0;
            grant <= {NUM_MASTERS{TCA_GRANT_RST}};
            padOut <= {PIN_W{TCA_PIN_RST}};
            padOutEn <= TCA_OE_RST;
        end else if (ce) begin
            state <= next_state;
            owner <= next_owner;
            grant <= next_grant;
            padOut <= next_padOut;
            padOutEn <= next_padOutEn;
        end
    end

    // =========================================================================
    // Pad input path
    // =========================================================================
    // sampled input
    tca_pin_sync #(
        .W(PIN_W)
    ) u_pin_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .ce(ce),
        .pinRaw(padIn),
        .pinSync(pinIn)
    );

    // =========================================================================
    // Checks
    // =========================================================================
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    a_reset_idle: assert property (@(posedge mclk) disable iff (1'b0)
        !rst_b |-> (grant == '0 && state == TCA_ARB_IDLE))
        else $error("grant or state not idle during reset");

    a_grant_onehot: assert property ($onehot0(grant))
        else $error("more than one master granted");

    a_freeze_grant: assert property (!ce |=> $stable(grant))
        else $error("grant changed while clock enable low");

    a_freeze_pads: assert property (
        !ce |=> $stable(padOutEn) && $stable(padOut) && $stable(pinIn))
        else $error("pad state changed while clock enable low");

    a_pad_idle: assert property (ce && grant == '0 |=> !padOutEn)
        else $error("pads driven with no owner");

    a_pin_follow: assert property (
        (ce && $stable(padIn)) [*4] |=> pinIn == $past(padIn))
        else $error("sampled pin input did not follow a stable pad");

    for (genvar i = 0; i < NUM_MASTERS; i++) begin : g_chk
        sequence sDrop;
            ce && grant[i] && !request[i];
        endsequence

        sequence sSoleAsk;
            ce && request == oneHot(OWN_W'(i));
        endsequence

        a_sole_ask: assert property (
            sSoleAsk and (state == TCA_ARB_IDLE) |=> grant[i])
            else $error("idle arbiter did not grant sole requester");

        a_grant_keep: assert property (ce && request[i] && grant[i] |=> grant[i])
            else $error("grant removed while request held");

        a_wait_refused: assert property (
            ce && grant != '0 && !grant[i] && ownerReq |=> !grant[i])
            else $error("waiting master granted while owner held access");

        a_grant_release: assert property (sDrop |=> !grant[i] ##0 state == TCA_ARB_IDLE)
            else $error("grant not removed one cycle after request dropped");

        a_rearb_again: assert property (sDrop ##1 sSoleAsk |=> grant[i])
            else $error("immediate re-request of lone master not granted");

        a_no_spurious: assert property (ce && !request[i] && !grant[i] |=> !grant[i])
            else $error("grant without a pending request");

        a_two_cycles: assert property (
            $rose(grant[i]) |-> $past(request[i] && !grant[i]))
            else $error("access shorter than two cycles");

        a_pad_owner: assert property (
            ce && grant[i] |=> padOutEn == $past(masterOutEn[i]))
            else $error("pad enable does not follow the owner");
    end
endmodule

// ### tca_master_model.sv
/*
 * Behavioural conduit master that asks the arbiter for the shared pins.
 * Assumes grant is registered on mclk and the bench pulses start.
 */
`timescale 1ns/10ps
module tca_master_model #(
    parameter int W = 16
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [7:0] len,
    input wire logic [W-1:0] value,
    input wire logic grant,
    output logic request,
    output logic [W-1:0] outVal,
    output logic outEn
);
    logic pending;
    logic [7:0] left;
    logic lastCycle;
    assign lastCycle = grant && pending && left == 8'h01;
    assign request = pending && !lastCycle;
    assign outEn = grant;
    // Not owning, the value is inverted so stale drive can never look right.
    assign outVal = grant ? value : ~value;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pending <= 1'h0;
            left <= 8'h00;
        end else if (lastCycle || !pending) begin
            pending <= start;
            left <= len;
        end else if (grant) begin
            left <= left - 8'h01;
        end
    end
endmodule

// ### tca_arbiter_tb.sv
/*
 * Self-checking bench for the conduit arbiter with two master models.
 * Assumes the hand-over latencies: grant one cycle, pads one, pad input four.
 */
`timescale 1ns/10ps
module tca_arbiter_tb;
    import tca_pkg::*;
    logic mclk, rst_b, ce, padOutEn;
    logic [1:0] grant, st;
    wire [1:0] request, masterOutEn;
    wire [31:0] masterOut;
    logic [15:0] pinIn, padIn, padOut, v0, v1;
    logic [7:0] ln;
    int fails, checked;

    tca_arbiter #(.NUM_MASTERS(2), .PIN_W(16)) DUT (.mclk(mclk), .rst_b(rst_b), .ce(ce),
        .request(request), .grant(grant), .masterOut(masterOut), .masterOutEn(masterOutEn),
        .pinIn(pinIn), .padIn(padIn), .padOut(padOut), .padOutEn(padOutEn));
    tca_master_model #(.W(16)) m0 (.mclk(mclk), .rst_b(rst_b), .start(st[0]), .len(ln),
        .value(v0), .grant(grant[0]), .request(request[0]), .outVal(masterOut[15:0]),
        .outEn(masterOutEn[0]));
    tca_master_model #(.W(16)) m1 (.mclk(mclk), .rst_b(rst_b), .start(st[1]), .len(ln),
        .value(v1), .grant(grant[1]), .request(request[1]), .outVal(masterOut[31:16]),
        .outEn(masterOutEn[1]));

    // =====================================================================
    // Shared tasks
    // =====================================================================
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic summarize();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // =====================================================================
    // Scenarios
    // =====================================================================
    task automatic single_access(input logic [7:0] n, input logic [15:0] v);
        int k;
        ln = n;
        v0 = v;
        st[0] = 1'h1;
        tick(1);
        st[0] = 1'h0;
        check("request", request, 2'h1);
        check("grant early", grant, 2'h0);
        tick(1);
        check("grant", grant, 2'h1);
        for (k = 1; k <= n; k++) begin
            tick(1);
            check("grant hold", grant, {1'h0, k < n});
            if (k == 1) begin
                check("pad value", padOut, v);
                check("pad enable", padOutEn, 1'h1);
            end
        end
        tick(1);
        check("pad idle", padOutEn, 1'h0);
    endtask
    task automatic back_to_back();
        logic [6:0] want;
        int k;
        want = 7'h36;
        ln = 8'h02;
        st[0] = 1'h1;
        tick(1);
        for (k = 0; k < 7; k++) begin
            check("regrant", grant[0], want[k]);
            if (k == 4) st[0] = 1'h0;
            tick(1);
        end
    endtask
    task automatic contention();
        int k, g0, g1;
        g0 = 0;
        g1 = 0;
        ln = 8'h02;
        v1 = 16'h0F0F;
        st = 2'h3;
        tick(1);
        st = 2'h0;
        for (k = 0; k < 10; k++) begin
            check("one owner", grant[0] & grant[1], 1'h0);
            if (grant[0] === 1'h1) g0++;
            if (grant[1] === 1'h1) g1++;
            tick(1);
        end
        check("waiting served", g0 * 16 + g1, 34);
    endtask
    task automatic freeze();
        int k;
        ln = 8'h06;
        st[0] = 1'h1;
        tick(2);
        st[0] = 1'h0;
        ce = 1'h0;
        padIn = 16'h5A5A;
        for (k = 0; k < 4; k++) begin
            tick(1);
            check("frozen grant", grant, 2'h1);
            check("frozen pin", pinIn, 16'h3C5A);
        end
        ce = 1'h1;
        tick(2);
        check("thawed grant", grant, 2'h0);
        tick(2);
        check("thawed pin", pinIn, 16'h5A5A);
    endtask
    task automatic pad_input(input logic [15:0] old, input logic [15:0] v);
        int k;
        padIn = v;
        for (k = 1; k <= 4; k++) begin
            tick(1);
            check("pin in", pinIn, k < 4 ? old : v);
        end
    endtask

    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        rst_b = 1'h0;
        ce = 1'h1;
        st = 2'h0;
        ln = 8'h01;
        v0 = 16'h0000;
        v1 = 16'h0000;
        padIn = 16'h0000;
        fails = 0;
        checked = 0;
        tick(12);
        rst_b = 1'h1;
        check("reset grant", {29'h0, grant, padOutEn}, 32'h0);
        check("reset pads", {padOut, pinIn}, 32'h0);
        single_access(8'h01, 16'hA5C3);
        single_access(8'h05, 16'h3C5A);
        back_to_back();
        contention();
        pad_input(16'h0000, 16'hC3A5);
        pad_input(16'hC3A5, 16'h3C5A);
        freeze();
        ln = 8'h04;
        st[0] = 1'h1;
        tick(3);
        rst_b = 1'h0;
        #1;
        check("reset mid", grant, 2'h0);
        tick(2);
        summarize();
    end
endmodule
